// ==== hw/cbtd_core.sv ====
// Branch decode, instruction sequencing and timer prescaler core
//
// Notes on behaviour
// - Instruction cycle is four core clocks.
// - External move cycles are two plus stretch.
// - Absolute call: two bytes, three cycles.
// - Long call, returns: four cycles each.
// - Absolute, long, short jumps decoded with lengths.
// - Carry and accumulator jumps: three cycles.
// - Bit-test jumps take four cycles.
// - Indirect pointer jump: one byte, three cycles.
// - Compare-and-jump forms take four cycles.
// - Decrement jumps: register three, direct four.
// - Both no-operation opcodes take one cycle.
// - Instructions take one to five cycles; external moves take two to nine.
// - Direct-to-direct move takes three cycles.
// - Bytes equal accesses; cycles normally equal bytes.
// - Timers advance every twelve clocks after reset.
// - Timers selectable to advance every four clocks.
module cbtd_core
  import cbtd_pkg::*;
(
  input  wire logic                  clk_sys,          // Core clock, 100 MHz
  input  wire logic                  resetn,           // Asynchronous reset, active low
  // Program memory
  output logic [15:0]                prog_addr_q,      // Fetch address
  output logic                       prog_rd_q,        // Fetch strobe, one instruction cycle
  input  wire logic [7:0]            prog_data,        // Fetched byte
  // Datapath conditions
  input  wire logic                  flag_carry,       // Carry flag
  input  wire logic [7:0]            acc_value,        // Accumulator
  input  wire logic                  test_bit,         // Addressed bit value
  input  wire logic                  cmp_equal,        // Compare operands equal
  input  wire logic                  dec_nonzero,      // Decremented value nonzero
  input  wire logic [15:0]           data_pointer,     // Active data pointer
  input  wire logic [15:0]           ret_addr,         // Address popped from stack
  // Sequencing results
  output logic [15:0]                pc_q,             // Program counter
  output logic                       instr_done_q,     // Instruction completed
  output logic                       branch_taken_q,   // Control transfer done
  output logic                       push_ret_q,       // Push return address
  output logic                       pop_ret_q,        // Return address consumed
  output logic                       irq_return_q,     // Interrupt return completed
  output logic                       bit_clear_q,      // Clear the tested bit
  output logic                       icycle_start_q,   // First clock of an instruction cycle
  output logic                       xdata_rd_q,       // External data read window
  output logic                       xdata_wr_q,       // External data write window
  output logic [NUM_TIMERS-1:0]      timer_tick_q,     // Timer increment pulses
  // SFR port
  input  wire logic [7:0]            sfr_addr,         // SFR address
  input  wire logic [7:0]            sfr_wdata,        // SFR write data
  input  wire logic                  sfr_wr,           // SFR write strobe
  input  wire logic                  sfr_rd,           // SFR read strobe
  output logic [7:0]                 sfr_rdata_q       // SFR read data
);

  // ==========================================================
  // Declarations
  cbtd_seq_t    seq_q;
  cbtd_seq_t    seq_d;
  logic [1:0]   phase_q;
  logic [1:0]   phase_d;
  logic [3:0]   icyc_q;
  logic [3:0]   icyc_d;
  logic [7:0]   op_q;
  logic [7:0]   b1_q;
  logic [7:0]   b2_q;
  logic [5:0]   stretch_q;
  logic [5:0]   stretch_d;
  logic [15:0]  pc_d;
  logic [15:0]  prog_addr_d;
  logic         prog_rd_d;
  logic         xdata_rd_d;
  logic         xdata_wr_d;
  logic [7:0]   sfr_rdata_d;

  cbtd_class_t  dec_class;
  logic [1:0]   dec_bytes;
  logic [3:0]   dec_cycles;

  // ==========================================================
  // Decode of the current opcode
  // In the opcode cycle the byte is still on the memory bus
  wire [7:0] op_now = (seq_q == SEQ_OPCODE) ? prog_data : op_q;

  cbtd_opdecode u_opdecode (
    .opcode       (op_now),
    .stretch      (stretch_q[STRETCH_LSB +: 3]),
    .instr_class  (dec_class),
    .instr_bytes  (dec_bytes),
    .instr_cycles (dec_cycles)
  );

  // ==========================================================
  // Branch condition select
  function automatic logic branch_cond(
    input cbtd_class_t cls,
    input logic        carry,
    input logic [7:0]  acc,
    input logic        bitv,
    input logic        equal,
    input logic        nonzero
  );
    logic ok;
    ok = 1'b0;
    case (cls)
      CL_CALL11, CL_CALL16, CL_RTN, CL_IRTN,
      CL_JMP11, CL_JMP16, CL_JMPR, CL_JMPI: ok = 1'b1;
      CL_JCY:  ok = carry;
      CL_JNCY: ok = !carry;
      CL_JAZ:  ok = (acc == 8'h00);
      CL_JANZ: ok = (acc != 8'h00);
      CL_JBS:  ok = bitv;
      CL_JBSC: ok = bitv;
      CL_JBN:  ok = !bitv;
      CL_CMPJ: ok = !equal;
      CL_DECJ: ok = nonzero;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : branch_cond

  // ==========================================================
  // Instruction cycle bookkeeping
  wire        end_icyc  = (phase_q == PHASE_LAST);
  wire [3:0]  icyc_next = icyc_q + 4'h1;
  wire        last_icyc = (icyc_next == dec_cycles);
  wire        instr_end = end_icyc && last_icyc;
  wire        fetch_next = instr_end || (icyc_next < {2'h0, dec_bytes});
  wire        opcode_end = end_icyc && (seq_q == SEQ_OPCODE);

  // ==========================================================
  // Target address generation
  wire [15:0] pc_seq   = pc_q + {14'h0000, dec_bytes};
  wire [7:0]  rel_off  = (dec_bytes == LEN3) ? b2_q : b1_q;
  wire [15:0] rel_ext  = {{8{rel_off[7]}}, rel_off};
  wire [15:0] tgt_abs  = {pc_seq[15:11], op_q[7:5], b1_q};
  wire [15:0] tgt_long = {b1_q, b2_q};
  wire [15:0] tgt_rel  = pc_seq + rel_ext;
  wire [15:0] tgt_ind  = data_pointer + {8'h00, acc_value};

  wire is_call   = (dec_class == CL_CALL11) || (dec_class == CL_CALL16);
  wire is_return = (dec_class == CL_RTN) || (dec_class == CL_IRTN);

  wire [15:0] target =
      ((dec_class == CL_CALL11) || (dec_class == CL_JMP11)) ? tgt_abs  :
      ((dec_class == CL_CALL16) || (dec_class == CL_JMP16)) ? tgt_long :
      (dec_class == CL_JMPI)                              ? tgt_ind  :
      is_return                                           ? ret_addr :
                                                            tgt_rel;

  // Condition only steers the target, never the cycle count
  wire taken = branch_cond(dec_class, flag_carry, acc_value, test_bit, cmp_equal, dec_nonzero);

  // ==========================================================
  // Next-state values for the sequencer
  assign phase_d = phase_q + 2'h1;

  assign icyc_d = instr_end ? 4'h0 :
                  end_icyc  ? icyc_next :
                              icyc_q;

  assign seq_d = instr_end ? SEQ_OPCODE :
                 end_icyc  ? SEQ_OPERAND :
                             seq_q;

  assign pc_d = !instr_end ? pc_q :
                taken      ? target :
                             pc_seq;

  // Fetch strobe and address stand for a whole instruction cycle
  assign prog_rd_d   = end_icyc ? fetch_next : prog_rd_q;
  assign prog_addr_d = !end_icyc ? prog_addr_q :
                       instr_end ? pc_d :
                                   pc_q + {12'h000, icyc_next};

  // External move window covers every cycle after the opcode cycle
  assign xdata_rd_d = instr_end  ? 1'b0 :
                      opcode_end ? (dec_class == CL_XRD) :
                                   xdata_rd_q;
  assign xdata_wr_d = instr_end  ? 1'b0 :
                      opcode_end ? (dec_class == CL_XWR) :
                                   xdata_wr_q;

  // ==========================================================
  // Clock-control register access
  wire sfr_hit = (sfr_addr == STRETCH_ADDR);

  assign stretch_d   = (sfr_wr && sfr_hit) ? sfr_wdata[5:0] : stretch_q;
  assign sfr_rdata_d = (sfr_rd && sfr_hit) ? {2'h0, stretch_q} : 8'h00;

  // ==========================================================
  // Sequencer state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_q   <= SEQ_OPCODE;
      phase_q <= 2'h0;
      icyc_q  <= 4'h0;
      pc_q    <= PC_RESET;
    end else begin
      seq_q   <= seq_d;
      phase_q <= phase_d;
      icyc_q  <= icyc_d;
      pc_q    <= pc_d;
    end
  end

  // Opcode and operand capture at the close of each fetch cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_q <= OP_NOP;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else begin
      if (opcode_end) begin
        op_q <= prog_data;
      end
      if (end_icyc && (icyc_q == 4'h1)) begin
        b1_q <= prog_data;
      end
      if (end_icyc && (icyc_q == 4'h2)) begin
        b2_q <= prog_data;
      end
    end
  end

  // Program memory fetch port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_rd_q   <= 1'b1;
      prog_addr_q <= PC_RESET;
    end else begin
      prog_rd_q   <= prog_rd_d;
      prog_addr_q <= prog_addr_d;
    end
  end

  // Completion pulses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      instr_done_q   <= 1'b0;
      branch_taken_q <= 1'b0;
      push_ret_q     <= 1'b0;
      pop_ret_q      <= 1'b0;
      irq_return_q   <= 1'b0;
      bit_clear_q    <= 1'b0;
    end else begin
      instr_done_q   <= instr_end;
      branch_taken_q <= instr_end && taken;
      push_ret_q     <= instr_end && is_call;
      pop_ret_q      <= instr_end && is_return;
      irq_return_q   <= instr_end && (dec_class == CL_IRTN);
      bit_clear_q    <= instr_end && (dec_class == CL_JBSC) && test_bit;
    end
  end

  // Instruction cycle marker and external move windows
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      icycle_start_q <= 1'b1;
      xdata_rd_q     <= 1'b0;
      xdata_wr_q     <= 1'b0;
    end else begin
      icycle_start_q <= end_icyc;
      xdata_rd_q     <= xdata_rd_d;
      xdata_wr_q     <= xdata_wr_d;
    end
  end

  // Clock-control register and its read port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stretch_q   <= STRETCH_RESET;
      sfr_rdata_q <= 8'h00;
    end else begin
      stretch_q   <= stretch_d;
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  // ==========================================================
  // Timer prescalers, one per timer/counter
  // A rate change applies to the running count at once; a count past the new limit wraps next clock
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_presc
      logic [3:0] presc_q;
      wire        fast  = stretch_q[TMR_FAST_LSB + gi];
      wire [3:0]  limit = fast ? TMR_FAST_CLKS - 4'h1 :
                                 TMR_SLOW_CLKS - 4'h1;
      wire        wrap  = (presc_q >= limit);

      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          presc_q          <= 4'h0;
          timer_tick_q[gi] <= 1'b0;
        end else begin
          presc_q          <= wrap ? 4'h0 : presc_q + 4'h1;
          timer_tick_q[gi] <= wrap;
        end
      end
    end
  endgenerate

endmodule : cbtd_core

// ==== hw/cbtd_pkg.sv ====
// Constants, opcodes and types for the branch decode and timing core
package cbtd_pkg;

  // ==========================================================
  // Clock-control register
  localparam logic [7:0] STRETCH_ADDR    = 8'h8E;  // Register address on the SFR port
  localparam logic [5:0] STRETCH_RESET   = 6'h01;  // Stretch of one: three-cycle external move
  localparam int         STRETCH_LSB     = 0;      // Stretch field, three bits
  localparam int         TMR_FAST_LSB    = 3;      // Timer fast-rate selects, one per timer
  localparam int         NUM_TIMERS      = 3;      // Timer/counters fed by the prescalers

  // ==========================================================
  // Timing
  localparam logic [1:0] PHASE_LAST      = 2'h3;   // Four core clocks per instruction cycle
  localparam logic [3:0] XMOVE_BASE      = 4'h2;   // External move base instruction cycles
  localparam logic [3:0] TMR_SLOW_CLKS   = 4'hC;   // Classic timer increment rate
  localparam logic [3:0] TMR_FAST_CLKS   = 4'h4;   // Fast timer increment rate
  localparam logic [15:0] PC_RESET       = 16'h0000;

  // ==========================================================
  // Lengths and cycle counts
  localparam logic [1:0] LEN1 = 2'h1;
  localparam logic [1:0] LEN2 = 2'h2;
  localparam logic [1:0] LEN3 = 2'h3;
  localparam logic [3:0] CYC1 = 4'h1;
  localparam logic [3:0] CYC3 = 4'h3;
  localparam logic [3:0] CYC4 = 4'h4;
  localparam logic [3:0] CYC5 = 4'h5;

  // ==========================================================
  // Opcodes
  localparam logic [4:0] OP_CALL11_LO = 5'h11;  // Low five bits of absolute call
  localparam logic [4:0] OP_JMP11_LO  = 5'h01;  // Low five bits of absolute jump
  localparam logic [7:0] OP_CALL16    = 8'h12;
  localparam logic [7:0] OP_RTN       = 8'h22;
  localparam logic [7:0] OP_IRTN      = 8'h32;
  localparam logic [7:0] OP_JMP16     = 8'h02;
  localparam logic [7:0] OP_JMPR      = 8'h80;
  localparam logic [7:0] OP_JCY       = 8'h40;
  localparam logic [7:0] OP_JNCY      = 8'h50;
  localparam logic [7:0] OP_JAZ       = 8'h60;
  localparam logic [7:0] OP_JANZ      = 8'h70;
  localparam logic [7:0] OP_JBS       = 8'h20;
  localparam logic [7:0] OP_JBN       = 8'h30;
  localparam logic [7:0] OP_JBSC      = 8'h10;
  localparam logic [7:0] OP_JMPI      = 8'h73;
  localparam logic [7:0] OP_CMPJ_DIR  = 8'hB5;
  localparam logic [7:0] OP_CMPJ_IMM  = 8'hB4;
  localparam logic [6:0] OP_CMPJ_IND  = 7'h5B;  // B6..B7 upper seven bits
  localparam logic [4:0] OP_CMPJ_REG  = 5'h17;  // B8..BF upper five bits
  localparam logic [4:0] OP_DECJ_REG  = 5'h1B;  // D8..DF upper five bits
  localparam logic [7:0] OP_DECJ_DIR  = 8'hD5;
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_NOP_ALT   = 8'hA5;
  localparam logic [7:0] OP_MOV_DD    = 8'h85;
  localparam logic [7:0] OP_MUL       = 8'hA4;
  localparam logic [7:0] OP_DIV       = 8'h84;
  localparam logic [2:0] OP_XMOVE_HI  = 3'h7;   // E0/E2/E3 read, F0/F2/F3 write
  localparam logic [1:0] OP_XMOVE_BAD = 2'h1;   // Low pair value that is not a move

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    CL_PLAIN, CL_CALL11, CL_CALL16, CL_RTN, CL_IRTN, CL_JMP11, CL_JMP16, CL_JMPR,
    CL_JCY, CL_JNCY, CL_JAZ, CL_JANZ, CL_JBS, CL_JBN, CL_JBSC, CL_JMPI,
    CL_CMPJ, CL_DECJ, CL_XRD, CL_XWR
  } cbtd_class_t;

  typedef enum logic {SEQ_OPCODE, SEQ_OPERAND} cbtd_seq_t;

endpackage : cbtd_pkg

// ==== hw/cbtd_opdecode.sv ====
// Opcode decoder: instruction class, byte length and instruction cycles
module cbtd_opdecode
  import cbtd_pkg::*;
(
  input  wire logic [7:0]  opcode,        // Opcode byte under decode
  input  wire logic [2:0]  stretch,       // External move stretch field
  output cbtd_class_t      instr_class,   // Instruction class
  output logic [1:0]       instr_bytes,   // Bytes fetched
  output logic [3:0]       instr_cycles   // Instruction cycles taken
);

  // ==========================================================
  // Class decode
  wire is_xmove = (opcode[7:5] == OP_XMOVE_HI) && (opcode[3:2] == 2'h0) && (opcode[1:0] != OP_XMOVE_BAD);

  assign instr_class =
      (opcode[4:0] == OP_CALL11_LO)                     ? CL_CALL11 :
      (opcode[4:0] == OP_JMP11_LO)                      ? CL_JMP11  :
      (opcode == OP_CALL16)                             ? CL_CALL16 :
      (opcode == OP_RTN)                                ? CL_RTN    :
      (opcode == OP_IRTN)                               ? CL_IRTN   :
      (opcode == OP_JMP16)                              ? CL_JMP16  :
      (opcode == OP_JMPR)                               ? CL_JMPR   :
      (opcode == OP_JCY)                                ? CL_JCY    :
      (opcode == OP_JNCY)                               ? CL_JNCY   :
      (opcode == OP_JAZ)                                ? CL_JAZ    :
      (opcode == OP_JANZ)                               ? CL_JANZ   :
      (opcode == OP_JBS)                                ? CL_JBS    :
      (opcode == OP_JBN)                                ? CL_JBN    :
      (opcode == OP_JBSC)                               ? CL_JBSC   :
      (opcode == OP_JMPI)                               ? CL_JMPI   :
      (opcode == OP_CMPJ_DIR) || (opcode == OP_CMPJ_IMM) ||
      (opcode[7:1] == OP_CMPJ_IND) || (opcode[7:3] == OP_CMPJ_REG) ? CL_CMPJ :
      (opcode == OP_DECJ_DIR) || (opcode[7:3] == OP_DECJ_REG)      ? CL_DECJ :
      (is_xmove && opcode[4])                           ? CL_XWR   :
      is_xmove                                          ? CL_XRD   :
                                                          CL_PLAIN;

  // ==========================================================
  // Length decode; one memory access per byte
  wire three_byte = (opcode == OP_CALL16) || (opcode == OP_JMP16) || (opcode == OP_JBS) ||
                    (opcode == OP_JBN) || (opcode == OP_JBSC) || (instr_class == CL_CMPJ) ||
                    (opcode == OP_DECJ_DIR) || (opcode == OP_MOV_DD);
  wire two_byte   = (instr_class == CL_CALL11) || (instr_class == CL_JMP11) || (opcode == OP_JMPR) ||
                    (opcode == OP_JCY) || (opcode == OP_JNCY) || (opcode == OP_JAZ) ||
                    (opcode == OP_JANZ) || (opcode[7:3] == OP_DECJ_REG);

  assign instr_bytes = three_byte ? LEN3 : two_byte ? LEN2 : LEN1;

  // ==========================================================
  // Cycle decode; plain opcodes other than multiply and divide take one cycle per byte
  wire four_cycle = three_byte && (opcode != OP_MOV_DD);
  wire ret_cycle  = (opcode == OP_RTN) || (opcode == OP_IRTN);

  assign instr_cycles =
      (instr_class == CL_XRD) || (instr_class == CL_XWR) ? XMOVE_BASE + {1'b0, stretch} :
      (opcode == OP_MUL) || (opcode == OP_DIV)  ? CYC5 :
      four_cycle || ret_cycle                   ? CYC4 :
      two_byte || (opcode == OP_JMPI) ||
      (opcode == OP_MOV_DD)                     ? CYC3 :
      (opcode == OP_NOP) || (opcode == OP_NOP_ALT) ? CYC1 :
                                                  {2'h0, instr_bytes};

endmodule : cbtd_opdecode

// ==== sim/cbtd_core_properties.sv ====
// Checker of cycle timing and pulse relations at the core ports
module cbtd_core_checker
  import cbtd_pkg::*;
(
  input wire logic                  clk_sys,        // Core clock
  input wire logic                  resetn,         // Reset, active low
  input wire logic                  icycle_start_q, // Cycle start
  input wire logic [15:0]           prog_addr_q,    // Fetch address
  input wire logic                  instr_done_q,   // Done pulse
  input wire logic                  branch_taken_q, // Taken pulse
  input wire logic                  push_ret_q,     // Push pulse
  input wire logic                  pop_ret_q,      // Pop pulse
  input wire logic                  irq_return_q,   // Interrupt return
  input wire logic                  sfr_rd,         // SFR read strobe
  input wire logic [7:0]            sfr_addr,       // SFR address
  input wire logic [7:0]            sfr_rdata_q,    // SFR read data
  input wire logic [NUM_TIMERS-1:0] timer_tick_q    // Timer ticks
);
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_cyc_len; icycle_start_q |=> !icycle_start_q [*3] ##1 icycle_start_q; endproperty
  a_cyc_len: assert property (p_cyc_len) else $error("cycle length wrong");
  property p_addr_hold; !icycle_start_q |-> $stable(prog_addr_q); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
  property p_done_edge; instr_done_q |-> icycle_start_q; endproperty
  a_done_edge: assert property (p_done_edge) else $error("done off boundary");
  property p_done_span; instr_done_q |=> !instr_done_q [*3] ##[1:33] instr_done_q; endproperty
  a_done_span: assert property (p_done_span) else $error("instruction length wrong");
  property p_call_push; push_ret_q |-> instr_done_q && branch_taken_q && !pop_ret_q; endproperty
  a_call_push: assert property (p_call_push) else $error("push without call end");
  property p_interrupt_return; irq_return_q |-> pop_ret_q && instr_done_q && branch_taken_q; endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt return wrong");
  property p_sfr_other; sfr_rd && sfr_addr != 8'h8E |=> sfr_rdata_q == 8'h00; endproperty
  a_sfr_other: assert property (p_sfr_other) else $error("unmapped read not zero");
  property p_sfr_top; sfr_rd |=> sfr_rdata_q[7:6] == 2'h0; endproperty
  a_sfr_top: assert property (p_sfr_top) else $error("upper bits not zero");
  property p_tick; timer_tick_q[0] |-> ##[1:12] timer_tick_q[0]; endproperty
  a_tick: assert property (p_tick) else $error("timer tick late");
endmodule : cbtd_core_checker

bind cbtd_core cbtd_core_checker i_chk (.clk_sys, .resetn, .icycle_start_q, .prog_addr_q, .instr_done_q,
  .branch_taken_q, .push_ret_q, .pop_ret_q, .irq_return_q, .sfr_rd, .sfr_addr, .sfr_rdata_q, .timer_tick_q);

// ==== sim/cbtd_prog_mem_model.sv ====
// Program memory model that answers fetches after a set lag
module cbtd_prog_mem_model #(
  parameter int LAG = 0            // Clocks before the byte is valid
) (
  input  wire logic        clk_sys,     // Core clock
  input  wire logic [15:0] prog_addr_q, // Fetch address
  input  wire logic        prog_rd_q,   // Fetch strobe
  output logic [7:0]       prog_data    // Fetched byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [65536];
  logic [7:0]  last_q = 8'h5A;
  logic [15:0] prev_q = 16'h0000;
  int          age_q = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Age of the current address, in clocks
  always @(posedge clk_sys) begin
    prev_q <= prog_addr_q;
    age_q <= (prog_addr_q != prev_q) ? 0 : age_q + 1;
    if (prog_rd_q) last_q <= prog_data;
  end
  // Settled byte, otherwise a pattern that flips each clock while the strobe is high
  assign prog_data = (prog_rd_q && prog_addr_q == prev_q && age_q >= LAG) ? mem[prog_addr_q] : ~last_q;
endmodule : cbtd_prog_mem_model

// ==== sim/tb.sv ====
// Self-checking testbench for the branch decode and timing core
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals
  logic        clk_sys = 1'b0, resetn = 1'b0, flag_carry = 1'b0, test_bit = 1'b0;
  logic        cmp_equal = 1'b0, dec_nonzero = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0]  acc_value = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, prog_data, sfr_rdata_q;
  logic [15:0] data_pointer = 16'h0300, ret_addr = 16'h0040, prog_addr_q, pc_q;
  logic [2:0]  timer_tick_q;
  logic        prog_rd_q, instr_done_q, branch_taken_q, push_ret_q, pop_ret_q;
  logic        irq_return_q, bit_clear_q, icycle_start_q, xdata_rd_q, xdata_wr_q;
  int          fails = 0, cmp_count = 0, n;
  always #5 clk_sys = ~clk_sys;
  cbtd_core i_dut (.clk_sys, .resetn, .prog_addr_q, .prog_rd_q, .prog_data, .flag_carry, .acc_value,
    .test_bit, .cmp_equal, .dec_nonzero, .data_pointer, .ret_addr, .pc_q, .instr_done_q, .branch_taken_q,
    .push_ret_q, .pop_ret_q, .irq_return_q, .bit_clear_q, .icycle_start_q, .xdata_rd_q, .xdata_wr_q,
    .timer_tick_q, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q);
  cbtd_prog_mem_model #(.LAG(2)) i_mem (.clk_sys, .prog_addr_q, .prog_rd_q, .prog_data);
  // ==========================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Place one instruction at the fetch address and time it
  task automatic exec(input logic [7:0] op, b1, input int len, cyc, input logic tk, input logic [15:0] tgt);
    logic [15:0] a, x;
    int          k;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      if (instr_done_q === 1'b1) break;
    end
    a = pc_q;
    i_mem.mem[a] = op;
    i_mem.mem[a + 16'h1] = b1;
    i_mem.mem[a + 16'h2] = 8'h00;
    k = 0;
    x = 16'h0000;
    repeat (40) begin
      @(posedge clk_sys);
      #1;
      k++;
      x += {14'h0, xdata_wr_q, xdata_rd_q};
      if (instr_done_q === 1'b1) break;
    end
    chk("cycles", 16'(cyc * 4), 16'(k));
    chk("pc", (tgt === 16'hFFFF) ? a + 16'(len) : tgt, pc_q);
    chk("taken", {15'h0000, tk}, {15'h0000, branch_taken_q});
    chk("xdata", (op[7:5] == 3'h7) ? 16'((cyc - 1) * (op[4] ? 8 : 4)) : 16'h0000, x);
    chk("bit_clear", {15'h0000, (op == 8'h10) && tk}, {15'h0000, bit_clear_q});
    i_mem.mem[pc_q] = 8'h00;
  endtask : exec
  task automatic sfr_write(input logic [7:0] a, d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] a, e);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1;
    chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata_q});
  endtask : sfr_read
  // Clocks between two ticks of one timer
  task automatic gap(input int t, input logic [15:0] e);
    n = 0;
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      if (timer_tick_q[t] === 1'b1) break;
    end
    repeat (30) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (timer_tick_q[t] === 1'b1) break;
    end
    chk("tick_gap", e, 16'(n));
  endtask : gap
  // ==========================================
  // Scenarios
  task automatic t_plain();
    exec(8'h00, 8'h00, 1, 1, 1'b0, 16'hFFFF);
    exec(8'hA5, 8'h00, 1, 1, 1'b0, 16'hFFFF);
    exec(8'h85, 8'h30, 3, 3, 1'b0, 16'hFFFF);
    exec(8'hA4, 8'h00, 1, 5, 1'b0, 16'hFFFF);
    $display("test plain done");
  endtask : t_plain
  task automatic t_jump();
    exec(8'h01, 8'h80, 2, 3, 1'b1, 16'h0080);
    exec(8'h31, 8'h00, 2, 3, 1'b1, 16'h0100);
    exec(8'h80, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    exec(8'h02, 8'h12, 3, 4, 1'b1, 16'h1200);
    exec(8'h12, 8'h13, 3, 4, 1'b1, 16'h1300);
    exec(8'h22, 8'h00, 1, 4, 1'b1, 16'h0040);
    exec(8'h32, 8'h00, 1, 4, 1'b1, 16'h0040);
    acc_value <= 8'h10;
    exec(8'h73, 8'h00, 1, 3, 1'b1, 16'h0310);
    $display("test jump done");
  endtask : t_jump
  task automatic t_cond();
    logic [7:0] cj [6] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hBF};
    flag_carry <= 1'b1;
    exec(8'h40, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    exec(8'h50, 8'h00, 2, 3, 1'b0, 16'hFFFF);
    acc_value <= 8'h00;
    exec(8'h60, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    exec(8'h70, 8'h00, 2, 3, 1'b0, 16'hFFFF);
    acc_value <= 8'h05;
    exec(8'h70, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    test_bit <= 1'b1;
    exec(8'h20, 8'h00, 3, 4, 1'b1, 16'hFFFF);
    exec(8'h30, 8'h00, 3, 4, 1'b0, 16'hFFFF);
    exec(8'h10, 8'h00, 3, 4, 1'b1, 16'hFFFF);
    foreach (cj[i]) exec(cj[i], 8'h00, 3, 4, 1'b1, 16'hFFFF);
    cmp_equal <= 1'b1;
    exec(8'hB4, 8'h00, 3, 4, 1'b0, 16'hFFFF);
    dec_nonzero <= 1'b1;
    exec(8'hD8, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    exec(8'hDF, 8'h00, 2, 3, 1'b1, 16'hFFFF);
    exec(8'hD5, 8'h00, 3, 4, 1'b1, 16'hFFFF);
    $display("test cond done");
  endtask : t_cond
  task automatic t_xmove();
    sfr_read(8'h8E, 8'h01);
    exec(8'hE0, 8'h00, 1, 3, 1'b0, 16'hFFFF);
    sfr_write(8'h8E, 8'hFF);
    sfr_read(8'h8E, 8'h3F);
    sfr_write(8'h8E, 8'h00);
    exec(8'hF0, 8'h00, 1, 2, 1'b0, 16'hFFFF);
    sfr_read(8'h8F, 8'h00);
    sfr_write(8'h8E, 8'h01);
    $display("test xmove done");
  endtask : t_xmove
  task automatic t_timer();
    gap(0, 16'h000C);
    sfr_write(8'h8E, 8'h29);
    gap(0, 16'h0004);
    gap(1, 16'h000C);
    gap(2, 16'h0004);
    $display("test timer done");
  endtask : t_timer
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // ==========================================
  // Main sequence and hang guard
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_plain();
    t_jump();
    t_cond();
    t_xmove();
    t_timer();
    conclude();
  end
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule : tb
